//--- design/ssrs_buf.sv
// two-entry buffer with valid and ready on both sides and a flush
// assumes the same clock and reset as its parent
`timescale 1ns/1ps
module ssrs_buf
    import ssrs_pkg::*;
(
    input wire logic clk_in, // system clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic flush_in, // drop every entry
    input wire logic in_valid_in, // word offered
    output logic in_ready_out, // room for a word
    input wire logic [ssrs_pkg::STAGES-1:0] in_data_in, // offered word
    output logic out_valid_out, // word available
    input wire logic out_ready_in, // word taken
    output logic [ssrs_pkg::STAGES-1:0] out_data_out // head word
);
    import ssrs_pkg::*;

    logic [STAGES-1:0] mem [2];
    logic [STAGES-1:0] next_mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic next_wr_ptr;
    logic next_rd_ptr;
    logic [1:0] next_count;
    logic push;
    logic pop;

    // handshake flags are plain functions of the fill count
    assign in_ready_out = (count != BUF_DEPTH);
    assign out_valid_out = (count != BUF_EMPTY);
    assign out_data_out = mem[rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // next pointers, count and storage
    always_comb
    begin
        next_mem = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (flush_in)
        begin
            next_wr_ptr = PTR_ZERO;
            next_rd_ptr = PTR_ZERO;
            next_count = BUF_EMPTY;
        end
        else
        begin
            if (push)
            begin
                next_mem[wr_ptr] = in_data_in;
                next_wr_ptr = wr_ptr + PTR_STEP;
            end
            if (pop)
                next_rd_ptr = rd_ptr + PTR_STEP;
            if (push && !pop)
                next_count = count + CNT_STEP;
            else if (pop && !push)
                next_count = count - CNT_STEP;
        end
    end

    // register buffer state
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mem[0] <= WORD_ZERO;
            mem[1] <= WORD_ZERO;
            wr_ptr <= PTR_ZERO;
            rd_ptr <= PTR_ZERO;
            count <= BUF_EMPTY;
        end
        else
        begin
            mem <= next_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // the fill count never passes the depth
    a_buf_count_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        count <= BUF_DEPTH)
        else $error("buffer count above depth");
endmodule : ssrs_buf

//--- design/ssrs_pkg.sv
// package of constants for the serial-in parallel-out shift register with storage
// assumes a single 25 MHz clock domain; all pins are sampled through synchronisers
package ssrs_pkg;
    localparam int STAGES = 8; // shift stages and storage bits
    localparam int LAST_STAGE = STAGES - 1; // stage that drives the cascade output
    localparam int SYNC_PINS = 5; // pins passed through the synchroniser
    localparam int PIN_SER = 0; // serial data pin index
    localparam int PIN_SHCLK = 1; // shift chain clock pin index
    localparam int PIN_STCLK = 2; // storage load clock pin index
    localparam int PIN_SHCLR = 3; // shift clear pin index
    localparam int PIN_STCLR = 4; // storage clear pin index
    localparam logic [SYNC_PINS-1:0] SYNC_RESET = 5'h00; // pin sync reset value
    localparam logic [STAGES-1:0] WORD_ZERO = 8'h00; // cleared word
    localparam logic [1:0] BUF_DEPTH = 2'h2; // entries in the load buffer
    localparam logic [1:0] BUF_EMPTY = 2'h0; // empty fill count
    localparam logic PTR_ZERO = 1'h0; // buffer pointer reset
    localparam logic PTR_STEP = 1'h1; // buffer pointer increment
    localparam logic [1:0] CNT_STEP = 2'h1; // fill count increment
endpackage : ssrs_pkg

//--- design/ssrs_top.sv
// serial-in parallel-out shift register feeding a storage register
// assumes every pin input is asynchronous to clk_in and changes slower than clk_in
// assumes out_ready_in comes from logic on clk_in and needs no synchroniser
// assumes every pin phase lasts at least two clk_in periods, or a pin edge may be lost
// Function
// RQ1: an eight-stage shift chain loads uninverted into an eight-bit storage register on the pins.
// RQ2: chain and storage act only on rising edges of their own independent clock pins.
// RQ3: with both clocks tied, storage takes the chain as it was before that edge.
// RQ4: both clears act as levels with no clock edge of their own needed.
// RQ5: a low shift clear forces all stages and the cascade output low, storage untouched.
// RQ6: a low storage clear forces the parallel outputs low, the chain untouched.
// RQ7: a storage edge under shift clear with storage clear released loads all zeros.
// RQ8: a shift edge takes serial in into stage 0, moves stages up, former stage 6 to cascade.
// RQ9: a storage edge with both clears released copies each stage to its parallel output.
// RQ10: both clocks rising together shift the chain and store the pre-shift contents.
// RQ11: the last stage drives the cascade output so a downstream part can chain from it.
// RQ12: the host presents each bit before a shift edge, sends eight shifts, then a storage pulse.
`timescale 1ns/1ps
module ssrs_top
    import ssrs_pkg::*;
(
    input wire logic clk_in, // 25 MHz system clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic serial_in, // serial data pin
    input wire logic shift_chain_clock_in, // shift chain clock pin
    input wire logic storage_load_clock_in, // storage load clock pin
    input wire logic shift_clear_n_in, // shift clear pin, active low
    input wire logic storage_clear_n_in, // storage clear pin, active low
    input wire logic out_ready_in, // downstream accepts a parallel word
    output logic cascade_out, // last shift stage
    output logic [ssrs_pkg::STAGES-1:0] parallel_out, // storage register
    output logic load_ready_out // buffer can take a storage load
);
    import ssrs_pkg::*;

    logic [SYNC_PINS-1:0] pin_meta;
    logic [SYNC_PINS-1:0] pin_sync;
    logic shclk_prev;
    logic stclk_prev;
    logic [STAGES-1:0] chain;
    logic [STAGES-1:0] next_chain;
    logic [STAGES-1:0] store;
    logic [STAGES-1:0] next_store;
    logic next_load_ready;
    logic shift_rise;
    logic store_rise;
    logic shclr_off;
    logic stclr_off;
    logic [STAGES-1:0] load_word;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [STAGES-1:0] buf_out_data;

    // two-flop synchroniser per pin; only the second stage is read
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_PINS; gi++)
        begin : g_sync
            always_ff @(posedge clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    pin_meta[gi] <= SYNC_RESET[gi];
                    pin_sync[gi] <= SYNC_RESET[gi];
                end
                else
                begin
                    pin_meta[gi] <= (gi == PIN_SER) ? serial_in :
                                    (gi == PIN_SHCLK) ? shift_chain_clock_in :
                                    (gi == PIN_STCLK) ? storage_load_clock_in :
                                    (gi == PIN_SHCLR) ? shift_clear_n_in : storage_clear_n_in;
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    // a pin change reaches pin_sync two edges after it is made and its edge flag at that same
    // edge; the flag lasts a single cycle because the history register follows at once
    // rising edges of the two independent clock pins
    assign shift_rise = pin_sync[PIN_SHCLK] && !shclk_prev; // [RQ2]
    assign store_rise = pin_sync[PIN_STCLK] && !stclk_prev; // [RQ2]
    assign shclr_off = pin_sync[PIN_SHCLR];
    assign stclr_off = pin_sync[PIN_STCLR];

    // word offered for storage: zeros under shift clear, else the pre-shift chain
    assign load_word = shclr_off ? chain : WORD_ZERO; // [RQ3] [RQ7] [RQ10]

    // next shift chain, storage and ready flag
    always_comb
    begin
        next_chain = chain;
        next_store = store;
        next_load_ready = buf_in_ready;
        if (!shclr_off)
            next_chain = WORD_ZERO; // [RQ4] [RQ5]
        else if (shift_rise)
            next_chain = {chain[LAST_STAGE-1:0], pin_sync[PIN_SER]}; // [RQ8] [RQ1]
        if (!stclr_off)
            next_store = WORD_ZERO; // [RQ4] [RQ6]
        else if (buf_out_valid && out_ready_in)
            next_store = buf_out_data; // [RQ9] [RQ1]
    end

    // register chain, storage, edge history and ready flag
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            shclk_prev <= SYNC_RESET[PIN_SHCLK];
            stclk_prev <= SYNC_RESET[PIN_STCLK];
            chain <= WORD_ZERO;
            store <= WORD_ZERO;
            load_ready_out <= 1'h0;
        end
        else
        begin
            shclk_prev <= pin_sync[PIN_SHCLK];
            stclk_prev <= pin_sync[PIN_STCLK];
            chain <= next_chain;
            store <= next_store;
            load_ready_out <= next_load_ready;
        end
    end

    // outputs straight from flops
    assign cascade_out = chain[LAST_STAGE]; // [RQ11]
    assign parallel_out = store; // [RQ1]

    // storage loads queue here so a stalled receiver loses none of two words; a load into the full buffer is dropped
    ssrs_buf ssrs_buf_i (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .flush_in(!stclr_off),
        .in_valid_in(store_rise && stclr_off),
        .in_ready_out(buf_in_ready),
        .in_data_in(load_word),
        .out_valid_out(buf_out_valid),
        .out_ready_in(out_ready_in),
        .out_data_out(buf_out_data)
    );

    // the checks below work on the synchronised pins and the edge flags, so every
    // expectation is stated in clk_in cycles after the detect edge

    // shift moves every stage up by one and takes the serial bit
    a_shift_moves: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ8]
        shift_rise && shclr_off
        |=> chain == {$past(chain[LAST_STAGE-1:0]), $past(pin_sync[PIN_SER])})
        else $error("shift chain did not shift");
    // cascade follows former stage six
    a_cascade_stage: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ11]
        shift_rise && shclr_off |=> cascade_out == $past(chain[LAST_STAGE-1]))
        else $error("cascade output wrong after shift");
    // shift clear zeroes the chain and keeps storage
    a_shclr_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ5]
        !shclr_off && stclr_off && !(buf_out_valid && out_ready_in)
        |=> chain == WORD_ZERO && !cascade_out && $stable(parallel_out))
        else $error("shift clear misbehaved");
    // storage clear zeroes outputs and keeps the chain
    a_stclr_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ6]
        !stclr_off && shclr_off && !shift_rise |=> parallel_out == WORD_ZERO && $stable(chain))
        else $error("storage clear misbehaved");
    // clear acts with no clock edge present
    a_clear_no_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ4]
        !stclr_off && !store_rise |=> parallel_out == WORD_ZERO)
        else $error("storage clear needed an edge");
    // load under shift clear stores zeros
    a_load_zeros: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ7]
        store_rise && !shclr_off && stclr_off && !buf_out_valid && out_ready_in
        ##1 stclr_off && out_ready_in |=> parallel_out == WORD_ZERO)
        else $error("zeros not loaded");
    // load with both clears off copies the chain before any shift
    a_load_copy: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ9]
        store_rise && shclr_off && stclr_off && !buf_out_valid && out_ready_in
        ##1 stclr_off && out_ready_in |=> parallel_out == $past(chain, 2))
        else $error("storage did not copy chain");
    // tied clocks store the pre-shift chain while the chain moves on by one
    a_tied_lag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ10] [RQ3]
        store_rise && shift_rise && shclr_off && stclr_off && !buf_out_valid && out_ready_in
        ##1 stclr_off && shclr_off && out_ready_in
        |=> parallel_out == $past(chain, 2)
        && chain == {$past(chain[LAST_STAGE-1:0], 2), $past(pin_sync[PIN_SER], 2)})
        else $error("storage not one shift behind");
    // no change without an edge
    a_edge_only: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ2]
        shclr_off && !shift_rise |=> $stable(chain))
        else $error("chain changed without edge");

    // a shift edge under shift clear leaves the chain empty
    a_shift_ignored: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ5]
        !shclr_off && shift_rise |=> chain == WORD_ZERO && !cascade_out)
        else $error("shift taken under shift clear");
    // cascade output stays low for as long as the shift clear is seen
    a_cascade_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ5]
        !shclr_off |=> !cascade_out)
        else $error("cascade high under shift clear");
    // storage changes only through a load or a clear
    a_store_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ9]
        stclr_off && !(buf_out_valid && out_ready_in) |=> $stable(parallel_out))
        else $error("storage changed without a load");
    // a storage edge under storage clear leaves the outputs low
    a_stclr_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ6]
        !stclr_off && store_rise |=> parallel_out == WORD_ZERO)
        else $error("storage loaded under storage clear");
    // storage clear drops every queued load
    a_clear_flush: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ6]
        !stclr_off |=> !buf_out_valid)
        else $error("queued load kept under storage clear");
    // a storage edge into a full, stalled buffer is dropped and the buffer stays full
    a_full_drop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        store_rise && stclr_off && !buf_in_ready && !out_ready_in |=> !buf_in_ready)
        else $error("full buffer changed on a dropped load");

    // main scenarios: shift, tied clocks, stall, load under shift clear, edge under clear
    c_shift: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        shift_rise && shclr_off);
    c_tied: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        shift_rise && store_rise);
    c_stall: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        !buf_in_ready);
    c_load_zeros: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        store_rise && !shclr_off && stclr_off);
    c_store_cleared: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        store_rise && !stclr_off);
endmodule : ssrs_top

//--- testbench/ssrs_host.sv
// host controller model that drives the pins of the shift register with storage
// assumes clk_in is the bench clock; every pin changes on its falling edge
`timescale 1ns/1ps
module ssrs_host (
    input wire logic clk_in, // system clock
    output logic serial_out, // serial data to the device
    output logic shift_clk_out, // shift chain clock pin
    output logic store_clk_out, // storage load clock pin
    output logic shift_clear_n_out, // shift clear, active low
    output logic storage_clear_n_out // storage clear, active low
);
    // idle pin levels from time zero
    initial
    begin
        serial_out = 1'b0;
        shift_clk_out = 1'b0;
        store_clk_out = 1'b0;
        shift_clear_n_out = 1'b1;
        storage_clear_n_out = 1'b1;
    end
    // wait n falling edges
    task automatic hold(input int n);
        repeat (n) @(negedge clk_in);
    endtask : hold
    // one clock pin pulse; high for three cycles, then five low for the effect to land
    task automatic pulse(input logic sh, input logic st);
        hold(1);
        shift_clk_out = sh;
        store_clk_out = st; // same edge on both when tied
        hold(3);
        shift_clk_out = 1'b0;
        store_clk_out = 1'b0;
        hold(5);
    endtask : pulse
    // present a bit well before its shift edge, then leave the line inverted
    task automatic shift_bit(input logic b, input logic st);
        hold(1);
        serial_out = b;
        hold(3);
        pulse(1'b1, st);
        serial_out = ~b;
    endtask : shift_bit
    // eight shifts per device, first bit is the top bit of the word
    task automatic send_byte(input logic [7:0] w);
        for (int i = 7; i >= 0; i--)
            shift_bit(w[i], 1'b0);
    endtask : send_byte
    // set both clear levels and let them settle
    task automatic clears(input logic sh_n, input logic st_n);
        hold(1);
        shift_clear_n_out = sh_n;
        storage_clear_n_out = st_n;
        hold(6);
    endtask : clears
endmodule : ssrs_host

//--- testbench/ssrs_top_bench.sv
// self-checking bench for the shift register with storage
// assumes the host model drives every pin; the bench drives reset and out_ready_in
`timescale 1ns/1ps
module ssrs_top_bench;
    import ssrs_pkg::*;
    logic clk_in, rst_n_in, out_ready_in, serial, shclk, stclk, shclr_n, stclr_n;
    logic cascade, load_ready;
    logic [STAGES-1:0] par;
    int error_cnt = 0;
    int check_count = 0;
    ssrs_host ssrs_host_i (.clk_in(clk_in), .serial_out(serial), .shift_clk_out(shclk),
        .store_clk_out(stclk), .shift_clear_n_out(shclr_n), .storage_clear_n_out(stclr_n));
    ssrs_top ssrs_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .serial_in(serial),
        .shift_chain_clock_in(shclk), .storage_load_clock_in(stclk),
        .shift_clear_n_in(shclr_n), .storage_clear_n_in(stclr_n),
        .out_ready_in(out_ready_in), .cascade_out(cascade), .parallel_out(par),
        .load_ready_out(load_ready));
    // 25 MHz clock
    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // compare a single output bit
    task automatic chk_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            $display("ERROR %0t %s: got %b want %b", $time, what, got, exp);
            error_cnt++;
        end
    endtask : chk_bit
    // compare the parallel word
    task automatic chk_word(input logic [STAGES-1:0] got, input logic [STAGES-1:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("ERROR %0t parallel word: got %h want %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk_word
    // print the counts and the verdict, then stop
    task automatic end_of_test;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    // fill one word, then store it
    task automatic s_load;
        ssrs_host_i.send_byte(8'hA5);
        chk_bit(cascade, 1'b1, "cascade after byte");
        chk_word(par, 8'h00);
        ssrs_host_i.pulse(1'b0, 1'b1);
        chk_word(par, 8'hA5);
    endtask : s_load
    // one more shift, storage untouched until its own edge
    task automatic s_shift;
        ssrs_host_i.shift_bit(1'b0, 1'b0);
        chk_bit(cascade, 1'b0, "cascade after shift");
        chk_word(par, 8'hA5);
        ssrs_host_i.pulse(1'b0, 1'b1);
        chk_word(par, 8'h4A);
    endtask : s_shift
    // both clocks tied: storage lags one shift behind
    task automatic s_tied;
        ssrs_host_i.shift_bit(1'b1, 1'b1);
        chk_word(par, 8'h4A);
        chk_bit(cascade, 1'b1, "cascade tied");
        ssrs_host_i.pulse(1'b0, 1'b1);
        chk_word(par, 8'h95);
    endtask : s_tied
    // shift clear: chain and cascade low, shifts ignored, store loads zeros
    task automatic s_shift_clear;
        ssrs_host_i.clears(1'b0, 1'b1);
        chk_bit(cascade, 1'b0, "cascade under clear");
        chk_word(par, 8'h95);
        ssrs_host_i.shift_bit(1'b1, 1'b0);
        ssrs_host_i.pulse(1'b0, 1'b1);
        chk_word(par, 8'h00);
        ssrs_host_i.clears(1'b1, 1'b1);
        ssrs_host_i.pulse(1'b0, 1'b1);
        chk_word(par, 8'h00);
    endtask : s_shift_clear
    // storage clear: outputs low, chain kept, stores ignored meanwhile
    task automatic s_store_clear;
        ssrs_host_i.send_byte(8'hC3);
        ssrs_host_i.pulse(1'b0, 1'b1);
        chk_word(par, 8'hC3);
        ssrs_host_i.clears(1'b1, 1'b0);
        chk_word(par, 8'h00);
        chk_bit(cascade, 1'b1, "cascade under storage clear");
        ssrs_host_i.pulse(1'b0, 1'b1);
        chk_word(par, 8'h00);
        ssrs_host_i.clears(1'b1, 1'b1);
        ssrs_host_i.pulse(1'b0, 1'b1);
        chk_word(par, 8'hC3);
    endtask : s_store_clear
    // receiver stalls: two loads queue, a third is dropped, then drain in order
    task automatic s_buffer;
        @(negedge clk_in);
        out_ready_in = 1'b0;
        ssrs_host_i.send_byte(8'h5A);
        ssrs_host_i.pulse(1'b0, 1'b1);
        ssrs_host_i.send_byte(8'h81);
        ssrs_host_i.pulse(1'b0, 1'b1);
        chk_word(par, 8'hC3);
        chk_bit(load_ready, 1'b0, "buffer full");
        ssrs_host_i.send_byte(8'h3C);
        ssrs_host_i.pulse(1'b0, 1'b1);
        @(negedge clk_in);
        out_ready_in = 1'b1;
        @(negedge clk_in);
        chk_word(par, 8'h5A);
        @(negedge clk_in);
        chk_word(par, 8'h81);
        ssrs_host_i.hold(6);
        chk_word(par, 8'h81);
        chk_bit(load_ready, 1'b1, "buffer drained");
    endtask : s_buffer
    // reset, then the scenarios in turn
    initial
    begin
        rst_n_in = 1'b0;
        out_ready_in = 1'b1;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        rst_n_in = 1'b1;
        ssrs_host_i.hold(4);
        chk_word(par, 8'h00);
        s_load();
        s_shift();
        s_tied();
        s_shift_clear();
        s_store_clear();
        s_buffer();
        end_of_test();
    end
    // watchdog well beyond the expected run of about seven hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk_in);
        error_cnt++;
        end_of_test();
    end
endmodule : ssrs_top_bench
